// [sim/mode_link_properties.sv]
// Checker: timing relations on the link between the device and far ends.
// Assumes one clock; instantiated beside the carrier, watching the device reset.
`default_nettype none
module mode_link_properties (
    // Clock and device reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Config and command traffic
    input wire logic       cfg_valid,
    input wire logic [3:0] cfg_mode,
    input wire logic       cfg_pulldown,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_value,
    // Bus state and device answers
    input wire logic       suspended,
    input wire logic       pkt_slot,
    input wire logic       configured,
    input wire logic [3:0] mode_rpt,
    input wire logic       short_pkt,
    input wire logic       wake_req
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Valid stored modes are taken; an answer that lands while still in reset is not
    property p_load; presetn && cfg_valid && cfg_mode <= 4'h4
        |=> configured && mode_rpt == $past(cfg_mode); endproperty
    a_load: assert property (p_load) else $error("config not loaded");
    // An out-of-range stored value falls back to serial
    property p_bad; cfg_valid && cfg_mode > 4'h4 |=> mode_rpt == 4'h0; endproperty
    a_bad: assert property (p_bad) else $error("bad stored mode taken");
    property p_dflt; !configured |-> mode_rpt == 4'h0; endproperty
    a_dflt: assert property (p_dflt) else $error("mode not default");
    property p_bb; cmd_valid && configured && cmd_value == 8'h01 && mode_rpt != 4'h4
        |=> mode_rpt == 4'h5; endproperty
    a_bb: assert property (p_bb) else $error("bit-bang switch lost");
    property p_sfifo; cmd_valid && configured && cmd_value == 8'h40 && mode_rpt == 4'h1
        |=> mode_rpt == 4'h8; endproperty
    a_sfifo: assert property (p_sfifo) else $error("sync FIFO switch lost");
    // Fast serial can only come from the stored config, never from a command
    property p_fs; $past(configured) && mode_rpt == 4'h4 |-> $past(mode_rpt) == 4'h4; endproperty
    a_fs: assert property (p_fs) else $error("fast serial selected");
    property p_short; short_pkt |-> $past(pkt_slot) ##1 !short_pkt; endproperty
    a_short: assert property (p_short) else $error("short packet off slot");
    property p_mode; short_pkt |-> !(mode_rpt inside {4'h0, 4'h3, 4'h4}); endproperty
    a_mode: assert property (p_mode) else $error("flush in wrong mode");
    property p_wake; wake_req |-> suspended && !cfg_pulldown ##1 !wake_req; endproperty
    a_wake: assert property (p_wake) else $error("wake not allowed");
    c_sfifo: cover property (cmd_valid && cmd_value == 8'h40 && mode_rpt == 4'h1);
    c_short: cover property (short_pkt);
    c_wake: cover property (wake_req);
endmodule : mode_link_properties
`default_nettype wire

// [sim/tb_top.sv]
// Bench: both ends joined by the carrier; the far end is steered over APB.
// Assumes zero-wait APB and a device reset apart from the far end's reset.
`default_nettype none
module tb_top
    import mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0, pready, pslverr, fs_hold, err, flush_pend, pwrite = 1'b0;
    logic        presetn = 1'b0, dev_rstn = 1'b0, tx_avail = 1'b0, psel = 1'b0, penable = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  mode_out;
    int          num_errors, check_count;
    mode_link_if lk ();
    mode_flush_wake_dev #(.WAKE_DET_CYCLES(20)) i_mode_flush_wake_dev (.pclk(pclk),
        .presetn(dev_rstn), .link(lk), .tx_data_avail(tx_avail), .mode_out(mode_out),
        .fs_hold(fs_hold), .flush_pending(flush_pend));
    mode_flush_wake_ext #(.WAKE_LEN(24)) i_mode_flush_wake_ext (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
    mode_link_properties i_props (.pclk(pclk), .presetn(dev_rstn), .cfg_valid(lk.cfg_valid),
        .cfg_mode(lk.cfg_mode), .cfg_pulldown(lk.cfg_pulldown), .cmd_valid(lk.cmd_valid),
        .cmd_value(lk.cmd_value), .suspended(lk.suspended), .pkt_slot(lk.pkt_slot),
        .configured(lk.configured), .mode_rpt(lk.mode_rpt), .short_pkt(lk.short_pkt),
        .wake_req(lk.wake_req));
    initial begin
        forever #4 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk_mode(input logic [3:0] g, input logic [3:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t mode %h expected %h", $time, g, e);
        end
    endtask : chk_mode
    task automatic chk_flag(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_flag
    // One APB transfer; request held until pready is sampled high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge pclk);
        {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            num_errors++;
            wrap_up();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic dev_reset;
        dev_rstn <= 1'b0;
        repeat (3) @(posedge pclk);
        dev_rstn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_flag(lk.configured, 1'b1);
    endtask : dev_reset
    function automatic logic [3:0] nxt(input logic [3:0] s, c, input logic [7:0] k);
        if (k == CMD_RESTORE) return s;
        if (k == CMD_SFIFO) return (s == 4'h1) ? 4'h8 : c;
        if (s == 4'h4 || !(k inside {CMD_ABB, CMD_ENGINE, CMD_SBB})) return c;
        return (k == CMD_ABB) ? 4'h5 : (k == CMD_ENGINE) ? 4'h7 : 4'h6;
    endfunction : nxt
    initial begin
        logic [31:0] q;
        logic [3:0]  s, c, cfg;
        logic        fs, pd;
        logic [7:0]  cmds [6] = '{8'h40, 8'h01, 8'h04, 8'h10, 8'h02, 8'h00};
        void'($urandom(32'h01E56B48));
        repeat (3) @(posedge pclk);
        {presetn, dev_rstn} <= 2'b11;
        repeat (6) @(posedge pclk);
        chk_mode(mode_out, 4'h0);
        bus(8'h20, 1'b0, 32'h0, q);
        chk_flag(err, 1'b1);
        for (int i = 0; i < 6; i++) begin
            cfg = (i < 5) ? 4'(i) : 4'(5 + $urandom % 11);
            s = (i < 5) ? cfg : 4'h0;
            c = s;
            fs = 1'b0;
            wr(OFS_CFG, {28'h0, cfg});
            dev_reset();
            chk_mode(mode_out, s);
            foreach (cmds[j]) begin
                tx_avail <= 1'($urandom);
                wr(OFS_CMD, {24'h0, cmds[j]});
                repeat (3) @(posedge pclk);
                c = nxt(s, c, cmds[j]);
                fs = (cmds[j] == CMD_FS_HOLD) ? (s == 4'h4) : (cmds[j] == 8'h00) ? 1'b0 : fs;
                chk_mode(mode_out, c);
                chk_flag(fs_hold, fs);
                wr(OFS_PIN, 32'h1);
                repeat (8) @(posedge pclk);
                chk_flag(flush_pend, c inside {1, 2, 5, 6, 8});
                wr(OFS_SLOT, 32'h1);
                repeat (3) @(posedge pclk);
                bus(OFS_STAT, 1'b0, 32'h0, q);
                chk_flag(q[STAT_SHORT_BIT], c inside {1, 2, 5, 6, 8});
                wr(OFS_STAT, 32'h300);
            end
            $display("test stored mode %0d done", cfg);
        end
        for (int i = 0; i < 3; i++) begin
            pd = (i == 2);
            wr(OFS_CFG, {27'h0, pd, (i == 0) ? 4'h0 : 4'(1 + $urandom % 2)});
            dev_reset();
            wr(OFS_SUSP, 32'h1);
            wr(OFS_PIN, (i == 0) ? 32'h4 : 32'h2);
            repeat (40) @(posedge pclk);
            bus(OFS_STAT, 1'b0, 32'h0, q);
            chk_flag(q[STAT_WAKE_BIT], !pd);
            wr(OFS_STAT, 32'h300);
            $display("test wake %0d done", i);
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire

// [src/mode_flush_wake_dev.sv]
// Device end: loads the operating mode after reset, follows host mode-switch
// commands, turns flush pin edges into short packets and detects wake pulses.
// Assumes the far end answers the config request; pins pass through two-stage synchronisers.
//
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none

module mode_flush_wake_dev
    import mode_pkg::*;
#(
    parameter int WAKE_DET_CYCLES = WAKE_CYCLES  // Low time that counts as wake
)(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Link to host driver and external logic
    mode_link_if.dev        link,
    // User side
    input  wire logic       tx_data_avail,  // Device-to-host data is buffered
    output logic [3:0]      mode_out,       // Current operating mode
    output logic            fs_hold,        // Fast serial controller held in reset
    output logic            flush_pending   // Short packet waiting for a slot
);

    // Loader states
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,  // Waiting for config memory
        ST_RUN  = 2'b01   // Configured, accepting commands
    } load_state_t;

    load_state_t            state_r;       // Loader state
    mode_t                  cfg_mode_r;    // Mode held in config memory
    mode_t                  mode_r;        // Mode in force
    logic                   pulldown_r;    // Pull-down option from config
    logic                   fs_hold_r;     // Fast serial held in reset
    logic                   fw_meta_r;     // Flush pin, first stage
    logic                   fw_sync_r;     // Flush pin, synchronised
    logic                   fw_prev_r;     // Flush pin, one cycle older
    logic                   ri_meta_r;     // Ring pin, first stage
    logic                   ri_sync_r;     // Ring pin, synchronised
    logic                   pend_r;        // Flush flagged to host
    logic                   short_r;       // Short packet pulse
    logic                   wake_r;        // Wake request pulse
    logic                   wake_done_r;   // Wake already sent for this low
    logic [WAKE_CNT_W-1:0]  wake_cnt_r;    // Low-time counter
    logic                   running;       // Loader finished
    logic                   fw_fall;       // Synchronised falling edge
    logic                   flush_evt;     // Edge that counts as flush
    logic                   wake_src;      // Pin watched for wake
    logic                   wake_ok;       // Wake detection allowed

    assign running = (state_r == ST_RUN);

    // Loader: request config until it arrives, once per reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_LOAD;
        end else begin
            unique case (state_r)
                ST_LOAD: begin
                    if (link.cfg_valid) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;  // Only a reset reloads
                end
                default: begin
                    state_r <= ST_LOAD;
                end
            endcase
        end
    end

    // Handshake to config memory is combinational from the state
    assign link.cfg_req    = (state_r == ST_LOAD);
    assign link.configured = running;

    // Mode register: config load first, then host commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_mode_r <= MODE_UART;
            mode_r     <= MODE_UART;
            pulldown_r <= 1'b0;
        end else if (!running) begin
            if (link.cfg_valid) begin
                pulldown_r <= link.cfg_pulldown;
                // Unknown stored codes fall back to the default mode
                if (cfg_mode_ok(link.cfg_mode)) begin
                    cfg_mode_r <= mode_t'(link.cfg_mode);
                    mode_r     <= mode_t'(link.cfg_mode);
                end else begin
                    cfg_mode_r <= MODE_UART;
                    mode_r     <= MODE_UART;
                end
            end
        end else if (link.cmd_valid) begin
            unique case (link.cmd_value)
                CMD_RESTORE: begin
                    mode_r <= cfg_mode_r;
                end
                CMD_ABB: begin
                    // Fast serial is only reset by the host, never switched away
                    if (cfg_mode_r != MODE_FSER) begin
                        mode_r <= MODE_ABB;
                    end
                end
                CMD_SBB: begin
                    if (cfg_mode_r != MODE_FSER) begin
                        mode_r <= MODE_SBB;
                    end
                end
                CMD_ENGINE: begin
                    if (cfg_mode_r != MODE_FSER) begin
                        mode_r <= MODE_ENGINE;
                    end
                end
                CMD_SFIFO: begin
                    if (cfg_mode_r == MODE_AFIFO) begin
                        mode_r <= MODE_SFIFO;
                    end
                end
                default: begin
                    // Other values, including the hold value, leave the mode alone
                    mode_r <= mode_r;
                end
            endcase
        end
    end

    // Fast serial reset control; only meaningful when config chose fast serial
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_hold_r <= 1'b0;
        end else if (running && link.cmd_valid) begin
            if (link.cmd_value == CMD_FS_HOLD && cfg_mode_r == MODE_FSER) begin
                fs_hold_r <= 1'b1;
            end else if (link.cmd_value == CMD_RESTORE) begin
                fs_hold_r <= 1'b0;
            end
        end
    end

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_meta_r <= 1'b1;
            fw_sync_r <= 1'b1;
            fw_prev_r <= 1'b1;
            ri_meta_r <= 1'b1;
            ri_sync_r <= 1'b1;
        end else begin
            fw_meta_r <= link.flush_wake_n;
            fw_sync_r <= fw_meta_r;
            fw_prev_r <= fw_sync_r;
            ri_meta_r <= link.ring_indicator_n;
            ri_sync_r <= ri_meta_r;
        end
    end

    // One edge gives one request; a held low adds nothing
    assign fw_fall = fw_prev_r & ~fw_sync_r;
    // While suspended the pin means wake, not flush
    assign flush_evt = fw_fall && running && pin_mode_ok(mode_r)
                    && !link.suspended;

    // Flush flag: set by the edge, cleared when the host slot carries it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r  <= 1'b0;
            short_r <= 1'b0;
        end else begin
            // Short packet goes in the very next slot, latency timer skipped
            short_r <= link.pkt_slot && pend_r;
            if (flush_evt) begin
                pend_r <= 1'b1;
            end else if (link.pkt_slot) begin
                pend_r <= 1'b0;
            end
        end
    end

    // Wake source: ring input in serial mode, flush pin in pin modes
    assign wake_src = (mode_r == MODE_UART) ? ri_sync_r : fw_sync_r;
    assign wake_ok  = running && link.suspended && !pulldown_r
                   && (mode_r == MODE_UART || pin_mode_ok(mode_r));

    // Wake detector: a long enough low while suspended, one request per low.
    // Shorter glitches are ignored, which costs a counter but spares false wakes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_r  <= '0;
            wake_done_r <= 1'b0;
            wake_r      <= 1'b0;
        end else begin
            wake_r <= 1'b0;
            if (!wake_ok || wake_src) begin
                wake_cnt_r  <= '0;
                wake_done_r <= 1'b0;
            end else if (!wake_done_r) begin
                if (wake_cnt_r == WAKE_CNT_W'(WAKE_DET_CYCLES - 1)) begin
                    wake_r      <= 1'b1;
                    wake_done_r <= 1'b1;
                end else begin
                    wake_cnt_r <= wake_cnt_r + 1'b1;
                end
            end
        end
    end

    // Outputs, all from flip-flops
    assign link.mode_rpt  = mode_r;
    assign link.short_pkt = short_r;
    assign link.wake_req  = wake_r;
    assign mode_out       = mode_r;
    assign fs_hold        = fs_hold_r;
    // Pending does not depend on buffered data; an empty flush still sends
    assign flush_pending  = pend_r & (tx_data_avail | 1'b1);

endmodule : mode_flush_wake_dev

`default_nettype wire

// [src/mode_flush_wake_ext.sv]
// Far end: host driver and external logic, driven by software over APB.
// Holds the config memory image, issues commands, schedules packet slots,
// and pulses the flush/wake and ring pins. Zero-wait APB slave on pclk.
`default_nettype none

module mode_flush_wake_ext
    import mode_pkg::*;
#(
    parameter int WAKE_LEN = WAKE_CYCLES  // Wake pulse low time in cycles
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the device
    mode_link_if.ext         link
);

    logic [3:0]           cfg_mode_r;    // Config memory image: mode
    logic                 cfg_pd_r;      // Config memory image: pull-down
    logic                 cfg_valid_r;   // Config answer pulse
    logic                 cmd_valid_r;   // Command strobe
    logic [7:0]           cmd_val_r;     // Command value
    logic                 susp_r;        // Host suspended
    logic                 slot_r;        // Packet slot pulse
    logic                 pin_busy_r;    // A pin pulse is running
    logic                 pin_ring_r;    // Pulse is on the ring pin
    logic [PIN_CNT_W-1:0] pin_cnt_r;     // Remaining low cycles
    logic                 short_seen_r;  // Sticky: short packet seen
    logic                 wake_seen_r;   // Sticky: wake request seen
    logic [31:0]          prdata_r;      // Read data, latched in setup
    logic                 pslverr_r;     // Unmapped address, latched in setup
    logic                 wr;            // Write takes effect
    logic                 setup;         // Setup phase

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite;

    // Config memory and command registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_mode_r  <= CFG_MODE_RST;
            cfg_pd_r    <= 1'b0;
            cfg_valid_r <= 1'b0;
            cmd_valid_r <= 1'b0;
            cmd_val_r   <= 8'h00;
            susp_r      <= 1'b0;
            slot_r      <= 1'b0;
        end else begin
            // Memory answers one cycle after each request
            cfg_valid_r <= link.cfg_req & ~cfg_valid_r;
            cmd_valid_r <= wr && paddr == OFS_CMD;
            slot_r      <= wr && paddr == OFS_SLOT;
            if (wr && paddr == OFS_CMD) begin
                cmd_val_r <= pwdata[7:0];
            end
            if (wr && paddr == OFS_CFG) begin
                cfg_mode_r <= pwdata[3:0];
                cfg_pd_r   <= pwdata[CFG_PD_BIT];
            end
            if (wr && paddr == OFS_SUSP) begin
                susp_r <= pwdata[0];
            end
        end
    end

    // Pin pulse generator; requests while busy are dropped.
    // Software should stop feeding data before a flush to avoid overrun.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_busy_r <= 1'b0;
            pin_ring_r <= 1'b0;
            pin_cnt_r  <= '0;
        end else if (pin_busy_r) begin
            if (pin_cnt_r == PIN_CNT_W'(1)) begin
                pin_busy_r <= 1'b0;  // Release high
            end
            pin_cnt_r <= pin_cnt_r - 1'b1;
        end else if (wr && paddr == OFS_PIN) begin
            if (pwdata[PIN_FLUSH_BIT]) begin
                pin_busy_r <= 1'b1;
                pin_ring_r <= 1'b0;
                pin_cnt_r  <= PIN_CNT_W'(FLUSH_LOW_CYCLES);
            end else if (pwdata[PIN_WAKE_BIT] || pwdata[PIN_RING_BIT]) begin
                pin_busy_r <= 1'b1;
                pin_ring_r <= pwdata[PIN_RING_BIT] & ~pwdata[PIN_WAKE_BIT];
                pin_cnt_r  <= PIN_CNT_W'(WAKE_LEN);
            end
        end
    end

    // Sticky event flags: set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_seen_r <= 1'b0;
            wake_seen_r  <= 1'b0;
        end else begin
            if (link.short_pkt) begin
                short_seen_r <= 1'b1;
            end else if (wr && paddr == OFS_STAT && pwdata[STAT_SHORT_BIT]) begin
                short_seen_r <= 1'b0;
            end
            if (link.wake_req) begin
                wake_seen_r <= 1'b1;
            end else if (wr && paddr == OFS_STAT && pwdata[STAT_WAKE_BIT]) begin
                wake_seen_r <= 1'b0;
            end
        end
    end

    // Read data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            unique case (paddr)
                OFS_CMD:  prdata_r[7:0] <= cmd_val_r;
                OFS_CFG:  prdata_r[CFG_PD_BIT:0] <= {cfg_pd_r, cfg_mode_r};
                OFS_PIN:  prdata_r[0] <= pin_busy_r;
                OFS_SUSP: prdata_r[0] <= susp_r;
                OFS_SLOT: prdata_r <= 32'h0000_0000;
                OFS_STAT: prdata_r[STAT_WAKE_BIT:0] <= {wake_seen_r, short_seen_r,
                                                        3'h0, link.configured,
                                                        link.mode_rpt};
                default:  pslverr_r <= 1'b1;
            endcase
        end
    end

    // APB answers
    assign pready  = psel & penable;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r & psel & penable;

    // Link drive
    assign link.cfg_valid        = cfg_valid_r;
    assign link.cfg_mode         = cfg_mode_r;
    assign link.cfg_pulldown     = cfg_pd_r;
    assign link.cmd_valid        = cmd_valid_r;
    assign link.cmd_value        = cmd_val_r;
    assign link.suspended        = susp_r;
    assign link.pkt_slot         = slot_r;
    assign link.flush_wake_n     = ~(pin_busy_r & ~pin_ring_r);
    assign link.ring_indicator_n = ~(pin_busy_r & pin_ring_r);

endmodule : mode_flush_wake_ext

`default_nettype wire

// [src/mode_link_if.sv]
// Carrier between the bridge device end and the host driver / external logic end.
// Plain wires, no clocking; both ends run on the same pclk.
`default_nettype none

interface mode_link_if;
    // Config memory read
    logic       cfg_req;           // Device asks for stored config
    logic       cfg_valid;         // One-cycle answer
    logic [3:0] cfg_mode;          // Stored mode
    logic       cfg_pulldown;      // Stored pull-down option
    // Host commands and bus state
    logic       cmd_valid;         // One-cycle command strobe
    logic [7:0] cmd_value;         // Command value
    logic       suspended;         // Host has suspended the bus
    logic       pkt_slot;          // Host schedules one IN packet
    // Pins from external logic
    logic       flush_wake_n;      // Flush / wake pin, active low
    logic       ring_indicator_n;  // Ring input, active low
    // Device answers
    logic       configured;        // Config loaded, enumerated
    logic [3:0] mode_rpt;          // Current mode
    logic       short_pkt;         // Short packet sent in this slot
    logic       wake_req;          // Remote wake-up signalled

    modport dev (
        input  cfg_valid, cfg_mode, cfg_pulldown, cmd_valid, cmd_value,
        input  suspended, pkt_slot, flush_wake_n, ring_indicator_n,
        output cfg_req, configured, mode_rpt, short_pkt, wake_req
    );
    modport ext (
        output cfg_valid, cfg_mode, cfg_pulldown, cmd_valid, cmd_value,
        output suspended, pkt_slot, flush_wake_n, ring_indicator_n,
        input  cfg_req, configured, mode_rpt, short_pkt, wake_req
    );
endinterface : mode_link_if

`default_nettype wire

// [src/mode_pkg.sv]
// Shared constants for the mode-select / flush / wake block and its far end.
// Assumes one 125 MHz clock on both ends; WAKE_CYCLES sets defaults in both files, each counter width is used by one file.
`default_nettype none

package mode_pkg;

    // Clock rate and derived timing
    localparam int CLK_KHZ          = 125000;             // 125 MHz in kHz
    localparam int WAKE_MS          = 20;                 // Wake pulse length, ms
    localparam int WAKE_CYCLES      = WAKE_MS * CLK_KHZ;  // 2,500,000 cycles
    localparam int WAKE_CNT_W       = 22;                 // Wide enough for WAKE_CYCLES
    localparam int FLUSH_LOW_CYCLES = 4;                  // Flush strobe low time
    localparam int PIN_CNT_W        = 22;                 // Far-end pin timer width

    // Operating modes; codes 0..4 are the ones the config memory may hold
    typedef enum logic [3:0] {
        MODE_UART    = 4'h0,  // Asynchronous serial (default)
        MODE_AFIFO   = 4'h1,  // Asynchronous parallel FIFO
        MODE_CPUFIFO = 4'h2,  // Processor-style FIFO
        MODE_HDSER   = 4'h3,  // Variable-width half-duplex serial bus
        MODE_FSER    = 4'h4,  // Fast opto-isolatable serial
        MODE_ABB     = 4'h5,  // Asynchronous bit-bang
        MODE_SBB     = 4'h6,  // Synchronous bit-bang
        MODE_ENGINE  = 4'h7,  // Multi-protocol serial engine
        MODE_SFIFO   = 4'h8   // Synchronous parallel FIFO
    } mode_t;

    // Host mode-switch command values
    localparam logic [7:0] CMD_RESTORE = 8'h00;  // Back to stored mode, fast serial released
    localparam logic [7:0] CMD_ABB     = 8'h01;
    localparam logic [7:0] CMD_ENGINE  = 8'h02;
    localparam logic [7:0] CMD_SBB     = 8'h04;
    localparam logic [7:0] CMD_FS_HOLD = 8'h10;  // Hold fast serial controller in reset
    localparam logic [7:0] CMD_SFIFO   = 8'h40;

    // Far-end register map (byte offsets, one word each)
    localparam logic [7:0] OFS_CMD  = 8'h00;  // RW: command value, a write issues one command
    localparam logic [7:0] OFS_CFG  = 8'h04;  // RW: stored mode and pull-down option
    localparam logic [7:0] OFS_PIN  = 8'h08;  // W: pin pulse requests, R: busy
    localparam logic [7:0] OFS_SUSP = 8'h0C;  // RW: host suspended level
    localparam logic [7:0] OFS_SLOT = 8'h10;  // W: host schedules one packet slot
    localparam logic [7:0] OFS_STAT = 8'h14;  // R: device state, W1C sticky events

    // Field positions
    localparam int CFG_PD_BIT     = 4;
    localparam int PIN_FLUSH_BIT  = 0;
    localparam int PIN_WAKE_BIT   = 1;
    localparam int PIN_RING_BIT   = 2;
    localparam int STAT_CONF_BIT  = 4;
    localparam int STAT_SHORT_BIT = 8;
    localparam int STAT_WAKE_BIT  = 9;

    // Reset values
    localparam logic [3:0] CFG_MODE_RST = 4'h0;

    // Modes the config memory may select
    function automatic logic cfg_mode_ok(input logic [3:0] m);
        cfg_mode_ok = (m <= 4'(MODE_FSER));
    endfunction : cfg_mode_ok

    // Modes in which the flush/wake pin is live: FIFO and bit-bang modes
    function automatic logic pin_mode_ok(input mode_t m);
        pin_mode_ok = (m == MODE_AFIFO) || (m == MODE_CPUFIFO) || (m == MODE_SFIFO)
                   || (m == MODE_ABB) || (m == MODE_SBB);
    endfunction : pin_mode_ok

endpackage : mode_pkg

`default_nettype wire
